// [inc/pds_defines.svh]
// Constants for the paged external data stretch sequencer
`ifndef PDS_DEFINES_SVH
`define PDS_DEFINES_SVH
`define PDS_LEN_W        6
`define PDS_STRETCH_CLKS 6'h04
`define PDS_DATA_CYC_4   6'h04
`define PDS_PS_ONE       2'b00
`define PDS_PS_TWO       2'b01
`define PDS_PS_FOUR      2'b10
`define PDS_PS_ALT       2'b11
`define PDS_STRB_NARROW  6'h01
`define PDS_STRB_WIDE    6'h02
`define PDS_SHORT_SETUP  6'h01
`define PDS_SHORT_HOLD   6'h01
`define PDS_SHORT_TRIM   6'h02
`define PDS_LONG_SETUP   6'h09
`define PDS_LONG_HOLD    6'h05
`define PDS_LONG_TRIM    6'h0E
`endif

// [inc/pds_pkg.sv]
// Types for the paged external data stretch sequencer
`include "pds_defines.svh"
package pds_pkg;
    typedef logic [`PDS_LEN_W-1:0] pds_len_t;
    typedef enum logic [4:0] {
        PDS_IDLE   = 5'b00001,
        PDS_LATCH  = 5'b00010,
        PDS_SETUP  = 5'b00100,
        PDS_STROBE = 5'b01000,
        PDS_HOLD   = 5'b10000
    } pds_state_t;
endpackage

// [rtl/pds_timing.sv]
// Phase lengths of one external access, in system clocks
`timescale 1ns/1ns
`default_nettype none
`include "pds_defines.svh"
module pds_timing (
    input  wire logic           data_i,        // Data move, not a fetch
    input  wire logic [2:0]     stretch_sel_i, // Stretch select
    input  wire logic           pg_en_i,       // Page bus enable
    input  wire logic [1:0]     pg_sel_i,      // Page bus select
    input  wire logic           miss_i,        // Page miss
    output pds_pkg::pds_len_t   latch_len_o,   // Latch phase clocks
    output pds_pkg::pds_len_t   setup_len_o,   // Setup phase clocks
    output pds_pkg::pds_len_t   strobe_len_o,  // Strobe clocks
    output pds_pkg::pds_len_t   hold_len_o     // Hold phase clocks
);
    import pds_pkg::*;

    // --------------------------------------------------------------
    // Stretch code to stretch cycles
    // --------------------------------------------------------------
    function automatic pds_len_t stretch_cycles(input logic [2:0] code);
        stretch_cycles = code[2] ? pds_len_t'(code[1:0]) + 6'h07
                                 : pds_len_t'(code[1:0]); // [R3]
    endfunction

    pds_len_t hit_len;
    pds_len_t cyc_len;
    pds_len_t base_len;
    pds_len_t w0;
    pds_len_t setup0;
    pds_len_t n;
    logic     four_clk;

    always_comb begin
        case (pg_sel_i) // [R15]
            `PDS_PS_ONE:  hit_len = 6'h01;
            `PDS_PS_TWO:  hit_len = 6'h02;
            `PDS_PS_FOUR: hit_len = 6'h04;
            default:      hit_len = 6'h02;
        endcase
        if (!pg_en_i)
            hit_len = `PDS_DATA_CYC_4; // [R14]
        // Alternate page bus and nonpage share one four-clock data cycle
        four_clk = !pg_en_i || (pg_sel_i == `PDS_PS_ALT); // [R10]
        cyc_len  = four_clk ? `PDS_DATA_CYC_4 : hit_len;
        base_len = pds_len_t'(cyc_len << 1); // [R4]
        // Widths are in system clocks; divider sets the oscillator ratio
        w0 = (pg_en_i && !pg_sel_i[1]) ? `PDS_STRB_NARROW : `PDS_STRB_WIDE; // [R11] [R12] [R13]
        setup0 = pds_len_t'((base_len - w0) >> 1);
        n = stretch_cycles(stretch_sel_i);
        if (!data_i) begin
            // Fetches never stretch
            latch_len_o  = miss_i ? hit_len : 6'h00; // [R18]
            setup_len_o  = 6'h00;
            strobe_len_o = hit_len;
            hold_len_o   = 6'h00;
        end else begin
            latch_len_o  = miss_i ? (four_clk ? 6'h01 : hit_len) : 6'h00; // [R9]
            setup_len_o  = (miss_i && four_clk) ? setup0 - 6'h01 : setup0;
            hold_len_o   = base_len - w0 - setup0;
            strobe_len_o = w0; // [R4]
            if (stretch_sel_i[2]) begin
                setup_len_o  = setup_len_o + `PDS_LONG_SETUP; // [R7]
                hold_len_o   = hold_len_o + `PDS_LONG_HOLD; // [R7]
                strobe_len_o = pds_len_t'(w0 + (n << 2) - `PDS_LONG_TRIM); // [R2]
                if (latch_len_o != 6'h00)
                    latch_len_o = latch_len_o + `PDS_STRETCH_CLKS; // [R8]
            end else if (n != 6'h00) begin
                setup_len_o  = setup_len_o + `PDS_SHORT_SETUP; // [R6]
                hold_len_o   = hold_len_o + `PDS_SHORT_HOLD; // [R6]
                strobe_len_o = pds_len_t'(w0 + (n << 2) - `PDS_SHORT_TRIM); // [R5] [R2]
            end
        end
    end
endmodule
`default_nettype wire

// [rtl/pds_seq.sv]
// External bus sequencer with stretched data moves in page mode
//
// Summary of operation
// [R1] Data moves stretch in page mode as they do in nonpage mode.
// [R2] Each stretch cycle adds four system clocks in every page setting.
// [R3] Codes 000-011 give 0-3 stretch cycles, 100-111 give 7-10.
// [R4] Code zero: no stretch, data move takes two basic cycles.
// [R5] Codes 1 to 3 extend the access by that many stretch cycles.
// [R6] First stretch adds one setup clock and one hold clock.
// [R7] Long range adds two stretch cycles setup, one stretch cycle hold.
// [R8] Long range page miss widens the latch strobe by one stretch cycle.
// [R9] Page hit access is shorter than a miss; no latch phase. Alternate bus data hits with codes 0-3 take as long as a miss here.
// [R10] Alternate page bus data timing equals nonpage timing. Long-range alternate hits here skip the widened latch and run 4 clocks shorter.
// [R11] Narrow page settings: strobe 1,3,7,11,15,19,23,27 clocks.
// [R12] Wide page settings: strobe 2,4,8,12,16,20,24,28 clocks.
// [R13] Oscillator widths scale with the clock divider setting.
// [R14] Page enable low reverts to the multiplexed nonpage bus.
// [R15] Page select sets hit/miss cycle clocks 1/2, 2/4, 4/8, 2/4.
// [R16] Upper address byte change is a miss, unchanged is a hit.
// [R17] On hits the latch strobe stays low and only low byte drives.
// [R18] Only data moves are stretched; fetches keep page-mode length.
// [R19] External part completes within the strobe it is given.
`timescale 1ns/1ns
`default_nettype none
`include "pds_defines.svh"
module pds_seq (
    input  wire logic       ref_clk_i,          // System clock
    input  wire logic       rstn_i,             // Sync reset, low
    input  wire logic       req_i,              // Access request
    input  wire logic       req_data_i,         // 1 data move, 0 fetch
    input  wire logic       req_write_i,        // Data write
    input  wire logic [15:0] req_addr_i,        // Address
    input  wire logic [7:0] req_wdata_i,        // Write data
    input  wire logic [2:0] stretch_select_i,   // Stretch code
    input  wire logic       page_bus_enable_i,  // Page mode on
    input  wire logic [1:0] page_bus_select_i,  // Page mode select
    output logic            req_ready_o,        // Idle, request taken
    output logic            done_o,             // Access finished pulse
    output logic [7:0]      rdata_o,            // Read data or opcode
    output logic            ale_o,              // Address latch strobe
    output logic            code_fetch_strobe_n_o, // Fetch strobe, low
    output logic            rd_n_o,             // Read strobe, low
    output logic            wr_n_o,             // Write strobe, low
    input  wire logic [7:0] low_byte_port_i,    // Low port pins in
    output logic [7:0]      low_byte_port_o,    // Low port pins out
    output logic            low_byte_port_oe_o, // Low port drive
    input  wire logic [7:0] high_byte_port_i,   // High port pins in
    output logic [7:0]      high_byte_port_o,   // High port pins out
    output logic            high_byte_port_oe_o // High port drive
);
    import pds_pkg::*;

    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    pds_state_t state_reg, state_next;
    pds_len_t   cnt_reg, cnt_next;
    pds_len_t   latch_len_reg, setup_len_reg, strobe_len_reg, hold_len_reg;
    pds_len_t   latch_len, setup_len, strobe_len, hold_len;
    logic [15:0] addr_reg, addr_next;
    logic [7:0] wdata_reg, wdata_next;
    logic       data_reg, data_next, write_reg, write_next;
    logic [7:0] last_page_reg, last_page_next;
    logic       page_valid_reg, page_valid_next;
    logic       last_data_reg, last_data_next;
    logic [7:0] rdata_reg, rdata_next;
    logic       done_reg, done_next;
    logic [7:0] lo_s1_reg, lo_s2_reg, hi_s1_reg, hi_s2_reg;
    logic       accept, page_miss, four_clk, last_clk;

    assign accept   = req_i && (state_reg == PDS_IDLE);
    assign four_clk = !page_bus_enable_i || (page_bus_select_i == `PDS_PS_ALT);
    // Single-clock page mode forces misses around data moves
    assign page_miss = !page_bus_enable_i || !page_valid_reg
        || (req_addr_i[15:8] != last_page_reg)
        || ((page_bus_select_i == `PDS_PS_ONE) && (req_data_i || last_data_reg)); // [R16]

    pds_timing u_timing (
        .data_i       (req_data_i),
        .stretch_sel_i(stretch_select_i),
        .pg_en_i      (page_bus_enable_i),
        .pg_sel_i     (page_bus_select_i),
        .miss_i       (page_miss),
        .latch_len_o  (latch_len),
        .setup_len_o  (setup_len),
        .strobe_len_o (strobe_len),
        .hold_len_o   (hold_len)
    );

    // --------------------------------------------------------------
    // Pin synchronisers
    // --------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        lo_s1_reg <= low_byte_port_i;
        lo_s2_reg <= lo_s1_reg;
        hi_s1_reg <= high_byte_port_i;
        hi_s2_reg <= hi_s1_reg;
    end

    // --------------------------------------------------------------
    // Sequencer
    // --------------------------------------------------------------
    assign last_clk = (cnt_reg == 6'h00);

    always_comb begin
        state_next      = state_reg;
        cnt_next        = (cnt_reg != 6'h00) ? cnt_reg - 6'h01 : 6'h00;
        addr_next       = addr_reg;
        wdata_next      = wdata_reg;
        data_next       = data_reg;
        write_next      = write_reg;
        last_page_next  = last_page_reg;
        page_valid_next = page_valid_reg;
        last_data_next  = last_data_reg;
        rdata_next      = rdata_reg;
        done_next       = 1'b0;
        case (state_reg)
            PDS_IDLE: begin
                if (accept) begin
                    addr_next       = req_addr_i;
                    wdata_next      = req_wdata_i;
                    data_next       = req_data_i; // [R1]
                    write_next      = req_write_i;
                    last_page_next  = req_addr_i[15:8]; // [R16]
                    page_valid_next = 1'b1;
                    last_data_next  = req_data_i;
                    // Hits skip the latch phase entirely
                    if (latch_len != 6'h00) begin // [R9] [R17]
                        state_next = PDS_LATCH;
                        cnt_next   = latch_len - 6'h01;
                    end else if (setup_len != 6'h00) begin
                        state_next = PDS_SETUP;
                        cnt_next   = setup_len - 6'h01;
                    end else begin
                        state_next = PDS_STROBE;
                        cnt_next   = strobe_len - 6'h01;
                    end
                end
            end
            PDS_LATCH: begin
                if (last_clk) begin
                    state_next = (setup_len_reg != 6'h00) ? PDS_SETUP : PDS_STROBE;
                    cnt_next   = (setup_len_reg != 6'h00) ? setup_len_reg - 6'h01
                                                          : strobe_len_reg - 6'h01;
                end
            end
            PDS_SETUP: begin
                if (last_clk) begin
                    state_next = PDS_STROBE;
                    cnt_next   = strobe_len_reg - 6'h01;
                end
            end
            PDS_STROBE: begin
                if (last_clk) begin
                    // Synchronised pins lag two clocks; see read window
                    // Alternate page bus returns fetches and data on the high port
                    rdata_next = (four_clk && page_bus_enable_i)
                               ? hi_s2_reg : lo_s2_reg; // [R19]
                    if (hold_len_reg != 6'h00) begin
                        state_next = PDS_HOLD;
                        cnt_next   = hold_len_reg - 6'h01;
                    end else begin
                        state_next = PDS_IDLE;
                        done_next  = 1'b1;
                    end
                end
            end
            PDS_HOLD: begin
                if (last_clk) begin
                    state_next = PDS_IDLE;
                    done_next  = 1'b1;
                end
            end
            default: state_next = PDS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            state_reg      <= PDS_IDLE;
            cnt_reg        <= 6'h00;
            latch_len_reg  <= 6'h00;
            setup_len_reg  <= 6'h00;
            strobe_len_reg <= 6'h00;
            hold_len_reg   <= 6'h00;
            addr_reg       <= 16'h0000;
            wdata_reg      <= 8'h00;
            data_reg       <= 1'b0;
            write_reg      <= 1'b0;
            last_page_reg  <= 8'h00;
            page_valid_reg <= 1'b0;
            last_data_reg  <= 1'b0;
            rdata_reg      <= 8'h00;
            done_reg       <= 1'b0;
        end else begin
            state_reg      <= state_next;
            cnt_reg        <= cnt_next;
            if (accept) begin
                latch_len_reg  <= latch_len;
                setup_len_reg  <= setup_len;
                strobe_len_reg <= strobe_len;
                hold_len_reg   <= hold_len;
            end
            addr_reg       <= addr_next;
            wdata_reg      <= wdata_next;
            data_reg       <= data_next;
            write_reg      <= write_next;
            last_page_reg  <= last_page_next;
            page_valid_reg <= page_valid_next;
            last_data_reg  <= last_data_next;
            rdata_reg      <= rdata_next;
            done_reg       <= done_next;
        end
    end

    // --------------------------------------------------------------
    // Pin drive
    // --------------------------------------------------------------
    logic in_latch, in_strobe, active, wr_drive;
    assign in_latch  = (state_reg == PDS_LATCH);
    assign in_strobe = (state_reg == PDS_STROBE);
    assign active    = (state_reg != PDS_IDLE);
    assign wr_drive  = active && !in_latch && data_reg && write_reg;

    assign req_ready_o = (state_reg == PDS_IDLE);
    assign done_o      = done_reg;
    assign rdata_o     = rdata_reg;
    assign ale_o       = in_latch; // [R17]
    assign code_fetch_strobe_n_o = !(in_strobe && !data_reg);
    assign rd_n_o      = !(in_strobe && data_reg && !write_reg);
    assign wr_n_o      = !(in_strobe && data_reg && write_reg);

    always_comb begin
        if (!page_bus_enable_i) begin
            // Nonpage: low port muxes low address and data
            low_byte_port_o     = in_latch ? addr_reg[7:0] : wdata_reg; // [R14]
            low_byte_port_oe_o  = in_latch || wr_drive;
            high_byte_port_o    = addr_reg[15:8];
            high_byte_port_oe_o = active;
        end else if (page_bus_select_i == `PDS_PS_ALT) begin
            low_byte_port_o     = addr_reg[7:0];
            low_byte_port_oe_o  = active;
            high_byte_port_o    = in_latch ? addr_reg[15:8] : wdata_reg;
            high_byte_port_oe_o = in_latch || wr_drive;
        end else begin
            // Hits drive the low byte only; upper stays in the latch
            low_byte_port_o     = wdata_reg;
            low_byte_port_oe_o  = wr_drive;
            high_byte_port_o    = in_latch ? addr_reg[15:8] : addr_reg[7:0]; // [R17]
            high_byte_port_oe_o = active;
        end
    end

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    logic strb;
    assign strb = !rd_n_o || !wr_n_o;

    sequence s_first_stretch;
        !strb [*2] ##1 strb [*3] ##1 !strb [*3] ##1 done_o;
    endsequence
    sequence s_wide_latch;
        ale_o [*6] ##1 !ale_o;
    endsequence

    a_narrow_width: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        accept && req_data_i && page_bus_enable_i && !page_bus_select_i[1]
        && stretch_select_i == 3'b011 |=> strobe_len_reg == 6'h0B) // [R11]
        else $error("narrow strobe width wrong");
    a_wide_width: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        accept && req_data_i && page_bus_enable_i && page_bus_select_i[1]
        && stretch_select_i == 3'b111 |=> strobe_len_reg == 6'h1C) // [R12]
        else $error("wide strobe width wrong");
    a_first_stretch: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        accept && req_data_i && page_bus_enable_i && page_bus_select_i == 2'b01
        && !page_miss && stretch_select_i == 3'b001 |=> s_first_stretch) // [R6]
        else $error("first stretch framing wrong");
    a_latch_widen: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        accept && req_data_i && page_bus_enable_i && page_bus_select_i == 2'b01
        && page_miss && stretch_select_i[2] |=> s_wide_latch) // [R8]
        else $error("latch strobe not widened");
    a_hit_no_latch: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        accept && !page_miss |=> !ale_o [*2]) // [R17]
        else $error("latch strobe on page hit");
    a_hit_bound: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        accept |-> ##[1:60] done_o) // [R9]
        else $error("access never finished");
    a_fetch_flat: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        accept && !req_data_i |=> setup_len_reg == 6'h00 && hold_len_reg == 6'h00) // [R18]
        else $error("fetch was stretched");
    a_alt_nonpage: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        accept && req_data_i && four_clk && stretch_select_i == 3'b000
        |=> latch_len_reg + setup_len_reg + strobe_len_reg + hold_len_reg
            == 6'h08 && strobe_len_reg == 6'h02) // [R10]
        else $error("four clock data timing wrong");
    a_nonpage_latch: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        accept && !page_bus_enable_i |=> ale_o) // [R14]
        else $error("nonpage access without latch");
    a_page_track: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        accept |=> last_page_reg == $past(req_addr_i[15:8])) // [R16]
        else $error("page byte not tracked");
endmodule
`default_nettype wire

// [tb/pds_mem_model.sv]
// Behavioural SRAM behind an address latch, page bus selects 00-10
`timescale 1ns/1ns
`default_nettype none
module pds_mem_model (
    input  wire logic       ref_clk_i, // System clock
    input  wire logic       ale_i,     // Latch strobe
    input  wire logic       rd_n_i,    // Read strobe, low
    input  wire logic       wr_n_i,    // Write strobe, low
    input  wire logic       fetch_n_i, // Fetch strobe, low
    input  wire logic [7:0] hi_pins_i, // Address pins
    input  wire logic [7:0] lo_pins_i, // Data pins
    output logic      [7:0] lo_drv_o   // Data drive
);
    logic [7:0]  mem [0:65535];
    logic [7:0]  hi_reg = 8'h00;
    logic [7:0]  last_reg = 8'h00;
    logic [15:0] addr;
    logic        en;
    // Upper byte only comes from the latch; hits never refresh it
    assign addr = {hi_reg, hi_pins_i};
    assign en = !rd_n_i || !fetch_n_i;
    // Released bus shows inverse of the last byte, never a stale copy
    assign lo_drv_o = en ? mem[addr] : ~last_reg;
    always @(posedge ref_clk_i) begin
        if (ale_i)
            hi_reg <= hi_pins_i;
        if (en)
            last_reg <= lo_drv_o;
        if (!wr_n_i)
            mem[addr] <= lo_pins_i;
    end
endmodule
`default_nettype wire

// [tb/test_paged_ext_data_stretch.sv]
// Directed bench for the paged external data stretch sequencer
`timescale 1ns/1ns
`default_nettype none
module test_paged_ext_data_stretch;
    logic        ref_clk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic        req_i = 1'b0;
    logic        req_data_i = 1'b0;
    logic        req_write_i = 1'b0;
    logic [15:0] req_addr_i = 16'h0000;
    logic [7:0]  req_wdata_i = 8'h00;
    logic [2:0]  sel_code = 3'b000;
    logic        pg_en = 1'b1;
    logic [1:0]  pg_sel = 2'b01;
    logic        ready, done, ale, fetch_n, rd_n, wr_n, lo_oe, hi_oe;
    logic [7:0]  rdata, lo_o, hi_o, lo_i, hi_i, mem_o;
    int          fail_count = 0;
    int          total_checks = 0;
    int          n_str, n_ale, n_fch, n_cyc, base, mc, s, c;
    int          nw [8] = '{1, 3, 7, 11, 15, 19, 23, 27};
    int          sc [8] = '{0, 1, 2, 3, 7, 8, 9, 10};
    int          hh [4] = '{1, 2, 4, 2};

    always #10 ref_clk_i = ~ref_clk_i;
    // Undriven high port shows the inverse of the value now on hi_o
    assign lo_i = lo_oe ? lo_o : mem_o;
    assign hi_i = hi_oe ? hi_o : ~hi_o;

    pds_seq DUT (
        .ref_clk_i             (ref_clk_i),
        .rstn_i                (rstn_i),
        .req_i                 (req_i),
        .req_data_i            (req_data_i),
        .req_write_i           (req_write_i),
        .req_addr_i            (req_addr_i),
        .req_wdata_i           (req_wdata_i),
        .stretch_select_i      (sel_code),
        .page_bus_enable_i     (pg_en),
        .page_bus_select_i     (pg_sel),
        .req_ready_o           (ready),
        .done_o                (done),
        .rdata_o               (rdata),
        .ale_o                 (ale),
        .code_fetch_strobe_n_o (fetch_n),
        .rd_n_o                (rd_n),
        .wr_n_o                (wr_n),
        .low_byte_port_i       (lo_i),
        .low_byte_port_o       (lo_o),
        .low_byte_port_oe_o    (lo_oe),
        .high_byte_port_i      (hi_i),
        .high_byte_port_o      (hi_o),
        .high_byte_port_oe_o   (hi_oe)
    );

    pds_mem_model MEM (
        .ref_clk_i (ref_clk_i),
        .ale_i     (ale),
        .rd_n_i    (rd_n),
        .wr_n_i    (wr_n),
        .fetch_n_i (fetch_n),
        .hi_pins_i (hi_o),
        .lo_pins_i (lo_i),
        .lo_drv_o  (mem_o)
    );

    function automatic logic [7:0] pat(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'hA5;
    endfunction

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // One access; counts strobe, latch, fetch and total clocks until done
    task automatic run(input logic d, input logic w, input logic [15:0] a, input logic [2:0] k);
        int i;
        @(negedge ref_clk_i);
        for (i = 0; i < 50 && ready !== 1'b1; i++)
            @(negedge ref_clk_i);
        if (ready !== 1'b1) begin
            fail_count++;
            end_of_test();
        end
        req_i = 1'b1;
        req_data_i = d;
        req_write_i = w;
        req_addr_i = a;
        req_wdata_i = pat(a);
        sel_code = k;
        {n_str, n_ale, n_fch, n_cyc} = '0;
        for (i = 0; i < 400; i++) begin
            @(negedge ref_clk_i);
            req_i = 1'b0;
            n_cyc++;
            n_str += (rd_n === 1'b0 || wr_n === 1'b0) ? 1 : 0;
            n_ale += (ale === 1'b1) ? 1 : 0;
            n_fch += (fetch_n === 1'b0) ? 1 : 0;
            if (done === 1'b1)
                break;
        end
        if (i == 400) begin
            fail_count++;
            end_of_test();
        end
    endtask

    initial begin
        repeat (15) @(negedge ref_clk_i);
        check("idle pins", 8'hF0, {ready, rd_n, wr_n, fetch_n, ale, done, lo_oe, hi_oe});
        check("reset rdata", 8'h00, rdata);
        @(negedge ref_clk_i);
        rstn_i = 1'b1;
        // Strobe width and stretch length per page select and code
        for (s = 0; s < 4; s++) begin
            pg_sel = 2'(s);
            run(1'b1, 1'b1, 16'h5500, 3'd0);
            run(1'b1, 1'b1, 16'h5500, 3'd0);
            base = n_cyc;
            for (c = 0; c < 8; c++) begin
                run(1'b1, 1'b1, 16'h5500 + 16'(c), 3'(c));
                check("write width", 8'(nw[c] + (s > 1 ? 1 : 0)), 8'(n_str));
                check("stretch clocks", 8'(4 * sc[c] + (s == 0 && c > 3 ? 4 : 0)),
                      8'(n_cyc - base));
                if (s == 1 || s == 2)
                    check("latch on hit", 8'd0, 8'(n_ale));
            end
        end
        // Nonpage bus latches every access
        pg_en = 1'b0;
        for (c = 0; c < 8; c++) begin
            run(1'b1, 1'b1, 16'h5500, 3'(c));
            check("nonpage width", 8'(nw[c] + 1), 8'(n_str));
            check("nonpage latch", 8'(c > 3 ? 5 : 1), 8'(n_ale));
        end
        // Page hit against page miss on reads
        pg_en = 1'b1;
        pg_sel = 2'b01;
        run(1'b1, 1'b1, 16'h1234, 3'd0);
        check("miss latch", 8'd2, 8'(n_ale));
        run(1'b1, 1'b1, 16'h3410, 3'd1);
        run(1'b1, 1'b0, 16'h1234, 3'd4);
        check("long miss latch", 8'd6, 8'(n_ale));
        check("read data", pat(16'h1234), rdata);
        mc = n_cyc;
        run(1'b1, 1'b0, 16'h1234, 3'd4);
        check("hit latch", 8'd0, 8'(n_ale));
        check("hit shorter", 8'd1, 8'(n_cyc < mc));
        run(1'b1, 1'b0, 16'h1234, 3'd2);
        check("hit read data", pat(16'h1234), rdata);
        // Fetches keep page length with the long stretch code 7
        for (s = 0; s < 4; s++) begin
            pg_sel = 2'(s);
            run(1'b0, 1'b0, 16'h7700 + 16'(s << 8), 3'd7);
            check("fetch width", 8'(hh[s]), 8'(n_fch));
            if (s < 3)
                check("fetch miss latch", 8'(hh[s]), 8'(n_ale));
            run(1'b0, 1'b0, 16'h7701 + 16'(s << 8), 3'd7);
            check("fetch hit width", 8'(hh[s]), 8'(n_fch));
            check("fetch no rdwr", 8'd0, 8'(n_str));
        end
        end_of_test();
    end
endmodule
`default_nettype wire
